/* inc/scit_regs.vh */
// timing constants for the single-cycle instruction timing decoder
`ifndef SCIT_REGS_VH
`define SCIT_REGS_VH
// ----------------------------------------
// clock
// ----------------------------------------
`define SCIT_CLK_PERIOD_NS   100
`define SCIT_CYCLES_PER_CLK  1
// ----------------------------------------
// byte lengths
// ----------------------------------------
`define SCIT_LEN_ONE         2'h1
`define SCIT_LEN_TWO         2'h2
`define SCIT_LEN_THREE       2'h3
// ----------------------------------------
// cycle counts and reset values
// ----------------------------------------
`define SCIT_CYC_1           4'h1
`define SCIT_CYC_2           4'h2
`define SCIT_CYC_3           4'h3
`define SCIT_CYC_4           4'h4
`define SCIT_CYC_9           4'h9
`define SCIT_XMOVE_BASE      4'h4
`define SCIT_WAIT_RESET      3'h0
`define SCIT_PC_RESET        16'h0000
`endif

/* rtl/scit_decode.v */
// combinational opcode to length, cycle count and class decode
`timescale 1ns/100ps
`include "scit_regs.vh"
module scit_decode (
    // opcode and wait state count
    input  wire [7:0] opcode,
    input  wire [2:0] waitStateCount,
    // decode results
    output reg  [1:0] byteLen,
    output reg  [3:0] cycles,
    output reg        isAbs,
    output reg        isJmpInd
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function isRegSrc;
        input [7:0] op;
        begin
            isRegSrc = (op[3] == 1'b1);
        end
    endfunction
    function isIndSrc;
        input [7:0] op;
        begin
            isIndSrc = (op[3:1] == 3'h3);
        end
    endfunction

    always @* begin
        byteLen  = `SCIT_LEN_ONE;
        cycles   = `SCIT_CYC_1;
        isAbs    = 1'b0;
        isJmpInd = 1'b0;
        if (opcode[4:0] == 5'h01 || opcode[4:0] == 5'h11) begin
            byteLen = `SCIT_LEN_TWO;
            cycles  = `SCIT_CYC_3;
            isAbs   = 1'b1;
        end else if (opcode[7:4] >= 4'h2 && opcode[7:4] <= 4'h6 ||
                     opcode[7:4] == 4'h9 || opcode[7:4] == 4'he) begin
            if (isRegSrc(opcode)) begin
                cycles = `SCIT_CYC_1;
            end else if (isIndSrc(opcode)) begin
                cycles = `SCIT_CYC_2;
            end else if (opcode[3:0] == 4'h4 || opcode[3:0] == 4'h5) begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
                if (opcode[7:4] == 4'he && opcode[0] == 1'b0) begin
                    byteLen = `SCIT_LEN_ONE;
                    cycles  = `SCIT_CYC_1;
                end
            end else if (opcode[3:0] == 4'h2) begin
                if (opcode[7:4] >= 4'h4) begin
                    byteLen = `SCIT_LEN_TWO;
                    cycles  = `SCIT_CYC_2;
                end
            end else if (opcode[3:0] == 4'h3) begin
                if (opcode[7:4] >= 4'h4) begin
                    byteLen = `SCIT_LEN_THREE;
                    cycles  = `SCIT_CYC_3;
                end
            end else if (opcode[3:0] == 4'h0 && opcode[7:4] == 4'hc ||
                         opcode[3:0] == 4'h0 && opcode[7:4] == 4'hd) begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
            end
        end
        case (opcode)
            8'h03, 8'h13, 8'h23, 8'h33: begin
                byteLen = `SCIT_LEN_ONE;
                cycles  = `SCIT_CYC_1;
            end
            8'h85: begin
                byteLen = `SCIT_LEN_THREE;
                cycles  = `SCIT_CYC_3;
            end
            8'h90: begin
                byteLen = `SCIT_LEN_THREE;
                cycles  = `SCIT_CYC_3;
            end
            8'h93, 8'h83: begin
                byteLen = `SCIT_LEN_ONE;
                cycles  = `SCIT_CYC_4;
            end
            8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
                byteLen = `SCIT_LEN_ONE;
                // at most 11 clocks with seven wait states
                cycles  = `SCIT_XMOVE_BASE + {1'b0, waitStateCount};
            end
            8'hc0, 8'hd0: begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
            end
            8'hc6, 8'hc7, 8'hd6, 8'hd7: begin
                byteLen = `SCIT_LEN_ONE;
                cycles  = `SCIT_CYC_2;
            end
            8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
            end
            8'h73: begin
                byteLen  = `SCIT_LEN_ONE;
                cycles   = `SCIT_CYC_3;
                isJmpInd = 1'b1;
            end
            8'ha3: begin
                cycles = `SCIT_CYC_3;
            end
            8'ha4: begin
                cycles = `SCIT_CYC_4;
            end
            8'h84: begin
                cycles = `SCIT_CYC_9;
            end
            8'hd4: begin
                cycles = `SCIT_CYC_2;
            end
            8'h22, 8'h32: begin
                cycles = `SCIT_CYC_4;
            end
            8'hc2, 8'hd2, 8'hb2: begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
            end
            8'h75: begin
                byteLen = `SCIT_LEN_THREE;
                cycles  = `SCIT_CYC_3;
            end
            8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
            8'h8e, 8'h8f, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab,
            8'hac, 8'had, 8'hae, 8'haf, 8'h76, 8'h77, 8'h78, 8'h79,
            8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'hf5, 8'h05,
            8'h15: begin
                byteLen = `SCIT_LEN_TWO;
                cycles  = `SCIT_CYC_2;
            end
            default: begin
            end
        endcase
    end
endmodule // scit_decode

/* rtl/scit_timing.v */
// instruction timing sequencer: length, cycles and program counter step
// Notes on behaviour
// - register-to-accumulator ALU ops: 1 byte, 1 clock
// - indirect-operand accumulator ops: 1 byte, 2 clocks
// - immediate or direct accumulator ops: 2 bytes, 2 clocks
// - logic immediate into direct byte: 3 bytes, 3
// - accumulator rotates: 1 byte, 1 clock
// - direct to direct move: 3 bytes, 3 clocks
// - load data pointer immediate: 3 bytes, 3
// - code byte load: 1 byte, 4 clocks
// - external data moves: 1 byte, 4 clocks
// - push or pop direct: 2 bytes, 2 clocks
// - exchange with indirect memory: 1 byte, 2
// - carry with direct bit ops: 2 bytes, 2
// - indirect jump via data pointer: 1 byte, 3
// - absolute call or jump: 2 bytes, 3
// - each counted cycle is one core clock
// - external moves add one clock per wait state
`timescale 1ns/100ps
`include "scit_regs.vh"
module scit_timing (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        clkEn,
    // fetch side
    input  wire        opValid,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operand1,
    input  wire [15:0] accPlusDataPointer,
    input  wire        branchTaken,
    input  wire [15:0] branchTarget,
    input  wire [2:0]  waitStateCount,
    // sequencer side
    output reg         opReady,
    output reg         busy,
    output reg         instrDone,
    output reg  [1:0]  curLen,
    output reg  [3:0]  curCycles,
    output reg  [15:0] pcOut
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam IDLE = 1'b0;
    localparam EXEC = 1'b1;

    wire [1:0] decLen;
    wire [3:0] decCycles;
    wire       decAbs;
    wire       decJmpInd;

    reg        state_q;
    reg        state_d;
    reg [3:0]  left_q;
    reg [3:0]  left_d;
    reg        abs_q;
    reg        jmpInd_q;
    reg [10:0] absTgt_q;
    reg [15:0] pc_d;

    scit_decode u_decode (
        .opcode         (opcode),
        .waitStateCount (waitStateCount),
        .byteLen        (decLen),
        .cycles         (decCycles),
        .isAbs          (decAbs),
        .isJmpInd       (decJmpInd)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        left_d  = left_q;
        pc_d    = pcOut;
        case (state_q)
            IDLE: begin
                if (opValid) begin
                    state_d = EXEC;
                    left_d  = decCycles;
                end
            end
            EXEC: begin
                left_d = left_q - 4'h1;
                if (left_q == 4'h1) begin
                    state_d = IDLE;
                    // step past instruction first, then apply any target
                    pc_d = pcOut + {14'h0000, curLen};
                    if (abs_q) begin
                        pc_d = {pc_d[15:11], absTgt_q};
                    end else if (jmpInd_q) begin
                        pc_d = accPlusDataPointer;
                    end else if (branchTaken) begin
                        pc_d = branchTarget;
                    end
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= IDLE;
            left_q    <= 4'h0;
            abs_q     <= 1'b0;
            jmpInd_q  <= 1'b0;
            absTgt_q  <= 11'h000;
            curLen    <= 2'h0;
            curCycles <= 4'h0;
            pcOut     <= `SCIT_PC_RESET;
            opReady   <= 1'b1;
            busy      <= 1'b0;
            instrDone <= 1'b0;
        end else if (clkEn) begin
            state_q   <= state_d;
            left_q    <= left_d;
            pcOut     <= pc_d;
            instrDone <= (state_q == EXEC) && (left_q == 4'h1);
            busy      <= (state_d == EXEC);
            opReady   <= (state_d == IDLE);
            if (state_q == IDLE && opValid) begin
                curLen    <= decLen;
                curCycles <= decCycles;
                abs_q     <= decAbs;
                jmpInd_q  <= decJmpInd;
                absTgt_q  <= {opcode[7:5], operand1};
            end
        end
    end
endmodule // scit_timing

/* dv/scit_fetch_model.sv */
// fetch unit stand-in: offers one opcode and holds it until taken
`timescale 1ns/100ps
module scit_fetch_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // bench request
    input  wire logic       go,
    input  wire logic [7:0] nextOp,
    input  wire logic [7:0] nextOpd,
    // core side
    input  wire logic       clkEn,
    input  wire logic       opReady,
    output logic            opValid,
    output logic [7:0]      opcode,
    output logic [7:0]      operand1
);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opValid  <= 1'b0;
            opcode   <= 8'h00;
            operand1 <= 8'h00;
        end else if (opValid && opReady && clkEn) begin
            // flip the released opcode so a stale copy is never reused
            opValid  <= 1'b0;
            opcode   <= ~opcode;
        end else if (go && !opValid) begin
            opValid  <= 1'b1;
            opcode   <= nextOp;
            operand1 <= nextOpd;
        end
    end
endmodule // scit_fetch_model

/* dv/scit_timing_assertions.sv */
// port checks for the instruction timing sequencer
`timescale 1ns/100ps
module scit_timing_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // fetch side
    input wire logic        clkEn,
    input wire logic        opValid,
    input wire logic [7:0]  opcode,
    input wire logic        branchTaken,
    input wire logic [2:0]  waitStateCount,
    // sequencer side
    input wire logic        opReady,
    input wire logic        busy,
    input wire logic        instrDone,
    input wire logic [1:0]  curLen,
    input wire logic [3:0]  curCycles,
    input wire logic [15:0] pcOut
);
    logic [3:0]  cntQ;
    logic [15:0] pcStartQ;
    logic        brQ;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cntQ     <= 4'h0;
            pcStartQ <= 16'h0000;
            brQ      <= 1'b0;
        end else if (clkEn && opReady && opValid) begin
            cntQ     <= 4'h0;
            pcStartQ <= pcOut;
            brQ      <= opcode[3:0] == 4'h1 || opcode == 8'h73;
        end else if (clkEn && busy) begin
            cntQ     <= cntQ + 4'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        clkEn && opReady && opValid;
    endsequence
    property p_dec(logic hit, logic [1:0] l, logic [3:0] c);
        s_take ##0 hit |=> curLen == l && curCycles == c;
    endproperty
    AST_ONE_ONE: assert property (p_dec(
        opcode[7:3] == 5'h05 || opcode[7:3] == 5'h13 ||
        opcode inside {8'h03, 8'h13, 8'h23, 8'h33}, 2'h1, 4'h1))
        else $error("one byte one clock class wrong");
    AST_ONE_TWO: assert property (p_dec(
        opcode inside {8'h26, 8'h27, 8'hc6, 8'hc7, 8'hd6, 8'hd7},
        2'h1, 4'h2)) else $error("indirect class wrong");
    AST_TWO_TWO: assert property (p_dec(
        opcode inside {8'h24, 8'h25, 8'hc0, 8'hd0, 8'h82, 8'hb0, 8'h72,
        8'ha0, 8'ha2, 8'h92}, 2'h2, 4'h2))
        else $error("two byte two clock class wrong");
    AST_THREE: assert property (p_dec(
        opcode inside {8'h43, 8'h53, 8'h63, 8'h85, 8'h90}, 2'h3, 4'h3))
        else $error("three byte class wrong");
    AST_CODE_LOAD: assert property (p_dec(
        opcode inside {8'h83, 8'h93}, 2'h1, 4'h4))
        else $error("code byte load wrong");
    AST_XMOVE: assert property (p_dec(
        opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}, 2'h1,
        4'h4 + $past(waitStateCount)))
        else $error("external move timing wrong");
    AST_IND_JUMP: assert property (p_dec(
        opcode == 8'h73, 2'h1, 4'h3))
        else $error("indirect jump timing wrong");
    AST_ABS: assert property (p_dec(
        opcode[3:0] == 4'h1, 2'h2, 4'h3))
        else $error("absolute branch timing wrong");
    AST_COUNT: assert property (instrDone |-> cntQ == curCycles)
        else $error("busy clocks differ from cycle count");
    AST_PC_STEP: assert property (instrDone && !brQ &&
        !$past(branchTaken) |-> pcOut == pcStartQ + {14'h0000, curLen})
        else $error("pc did not step by length");
    // a low enable must hold every counted cycle back
    AST_FREEZE: assert property (!clkEn |=> $stable(pcOut) &&
        $stable(busy) && $stable(curCycles) && $stable(instrDone))
        else $error("state moved while clock enable low");
endmodule // scit_timing_checker

bind scit_timing scit_timing_checker scit_timing_checker_inst (
    .mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .opValid(opValid),
    .opcode(opcode), .branchTaken(branchTaken),
    .waitStateCount(waitStateCount), .opReady(opReady), .busy(busy),
    .instrDone(instrDone), .curLen(curLen), .curCycles(curCycles),
    .pcOut(pcOut));

/* dv/scit_timing_bench.sv */
// self-checking bench for the instruction timing sequencer
`timescale 1ns/100ps
module scit_timing_bench;
    logic        mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, go = 1'b0;
    logic        branchTaken = 1'b0, opValid, opReady, busy, instrDone;
    logic [7:0]  nextOp = 8'h00, nextOpd = 8'h00, opcode, operand1;
    logic [2:0]  waitStateCount = 3'h0;
    logic [15:0] accPlusDataPointer = 16'h1234, branchTarget = 16'h0abc;
    logic [15:0] pcOut, pcExp = 16'h0000;
    logic [1:0]  curLen;
    logic [3:0]  curCycles;
    int          bad_count = 0, num_checks = 0, k = 0;
    // each row: opcode, bytes, clocks
    logic [15:0] rows [32] = '{16'h2811, 16'h2612, 16'h2422, 16'h2522,
        16'h5333, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'h8533,
        16'h9033, 16'h9314, 16'h8314, 16'he214, 16'he014, 16'hf214,
        16'hf014, 16'hc022, 16'hd022, 16'hc612, 16'hd612, 16'h8222,
        16'hb022, 16'h7222, 16'ha022, 16'h7313, 16'h2123, 16'h3123,
        16'ha222, 16'h9222, 16'h6333, 16'h9811};
    scit_timing scit_timing_inst (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .opValid(opValid), .opcode(opcode), .operand1(operand1),
        .accPlusDataPointer(accPlusDataPointer), .branchTaken(branchTaken),
        .branchTarget(branchTarget), .waitStateCount(waitStateCount),
        .opReady(opReady), .busy(busy), .instrDone(instrDone),
        .curLen(curLen), .curCycles(curCycles), .pcOut(pcOut));
    scit_fetch_model scit_fetch_model_inst (.mclk(mclk), .rst_n(rst_n),
        .go(go), .nextOp(nextOp), .nextOpd(nextOpd), .clkEn(clkEn),
        .opReady(opReady), .opValid(opValid), .opcode(opcode),
        .operand1(operand1));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one instruction from offer to completion, timed in whole clocks
    task automatic run(input logic [15:0] row, input logic [7:0] opd,
                       input logic [2:0] w);
        int n;
        logic [15:0] pa;
        n = 0;
        @(posedge mclk);
        nextOp <= row[15:8];
        nextOpd <= opd;
        waitStateCount <= w;
        go <= 1'b1;
        do begin
            @(negedge mclk);
            n++;
        end while (!(opValid && opReady) && n < 20);
        if (n >= 20) begin
            bad_count++;
            wrap_up();
        end
        @(posedge mclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!instrDone && n < 20);
        if (n >= 20) begin
            bad_count++;
            wrap_up();
        end
        pa = pcExp + {14'h0000, row[5:4]};
        pcExp = (row[15:8] == 8'h73) ? accPlusDataPointer :
            (row[11:8] == 4'h1) ? {pa[15:11], row[15:13], opd} :
            branchTaken ? branchTarget : pa;
        check("length", {14'h0000, curLen}, {14'h0000, row[5:4]});
        check("cycles", {12'h000, curCycles}, {12'h000, row[3:0]});
        // the wait ends one falling edge after the completing clock
        check("clocks", 16'(n - 1), {12'h000, row[3:0]});
        check("pc", pcOut, pcExp);
    endtask
    initial begin
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i])
            run(rows[i], 8'h5a, 3'h0);
        run(16'he01b, 8'h00, 3'h7);
        run(16'hf217, 8'h00, 3'h3);
        @(posedge mclk);
        branchTaken <= 1'b1;
        run(16'h0011, 8'h00, 3'h0);
        // freeze a three-clock move right after it is taken
        @(posedge mclk);
        branchTaken <= 1'b0;
        nextOp <= 8'h85;
        go <= 1'b1;
        repeat (2) @(posedge mclk);
        go <= 1'b0;
        clkEn <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        check("freeze", {13'h0, busy, instrDone, opReady}, 16'h4);
        @(posedge mclk);
        clkEn <= 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (!instrDone && k < 20);
        pcExp = pcExp + 16'h0003;
        check("frozen clocks", 16'(k - 1), 16'h0003);
        check("frozen pc", pcOut, pcExp);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        check("reset pc", pcOut, 16'h0000);
        check("reset state", {7'h00, opReady, busy, instrDone, curLen,
            curCycles}, 16'h0100);
        @(posedge mclk);
        rst_n <= 1'b1;
        pcExp = 16'h0000;
        run(16'h2123, 8'hff, 3'h0);
        wrap_up();
    end
endmodule // scit_timing_bench
